// *** dv/spc_mem_model.sv ***
/*
  Word memory partner for the execution block: one flat space for stack and code.
  Assumes one request at a time, held stable until the one-cycle acknowledge.
*/
module spc_mem_model (
  input  wire logic        clock_i,      // bench clock
  input  wire logic        slow_i,       // stretch every answer
  input  wire logic        mem_req_i,    // request level
  input  wire logic        mem_we_i,     // 1 = write
  input  wire logic [15:0] mem_addr_i,   // byte address
  input  wire logic [15:0] mem_wdata_i,  // write word
  output logic      [15:0] mem_rdata_o,  // read word, valid with ack
  output logic             mem_ack_o     // one-cycle done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:256-1];  // stack shares space with code
  int          cnt = 0;
  int          lim = 0;
  logic        skip = 1'b0;
  initial mem_ack_o = 1'b0;
  initial mem_rdata_o = 16'h0000;
  // read data toggles outside ack so a stale sample never matches by luck
  always @(posedge clock_i) begin
    mem_rdata_o <= ~mem_rdata_o;
    mem_ack_o <= 1'b0;
    if (mem_ack_o) begin
      skip <= 1'b1;
    end else if (skip) begin
      skip <= 1'b0;
    end else if (mem_req_i && cnt < (slow_i ? 8 : lim)) begin
      cnt <= cnt + 1;
    end else if (mem_req_i) begin
      mem_ack_o <= 1'b1;
      cnt <= 0;
      lim <= $urandom_range(0, 2);
      if (mem_we_i) mem[mem_addr_i[8:1]] <= mem_wdata_i;
      else mem_rdata_o <= mem[mem_addr_i[8:1]];
    end
  end
endmodule

// *** dv/subroutine_program_control_exec_bench.sv ***
/*
  Self-checking bench for the execution block: an integer reference of the
  instructions is compared with registers, status, trap outputs and memory.
  Assumes the AHB-Lite slave map of the package and the word memory partner.
*/
module subroutine_program_control_exec_bench
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_i, hsel, hwrite, hready, hresp, slow;
  logic        mem_req, mem_we, mem_ack, trap;
  logic [1:0]  htrans;
  logic [7:0]  trap_vec;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [31:0] haddr, hwdata, hrdata, v0;
  int          n_fail = 0, check_count = 0, traps_seen = 0, n_traps = 0;
  int          r[8], em[256], psw, dstv, vec, flg, rr, rs;

  spc_exec i_spc_exec (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp), .mem_req_o(mem_req),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
    .mem_ack_i(mem_ack), .trap_o(trap), .trap_vec_o(trap_vec));
  spc_mem_model i_spc_mem_model (.clock_i(clock_i), .slow_i(slow), .mem_req_i(mem_req),
    .mem_we_i(mem_we), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata),
    .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // trap is a one-cycle pulse, so every edge counts
  always @(posedge clock_i) if (trap === 1'b1) traps_seen <= traps_seen + 1;

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic give_up();
    n_fail++;
    final_report();
  endtask
  // waits for hready at a rising edge, bounded
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) give_up();
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] x;
    ahb(1'b1, a, 32'(d), x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0000_0000, d);
  endtask
  task automatic raise(input int bit_n, input int v);
    flg |= 1 << bit_n;
    vec = v;
    n_traps++;
  endtask

  // integer reference of one instruction
  task automatic model(input logic [15:0] ir);
    int lr, d, sp;
    lr = ir[8:6];
    sp = r[6];
    if ((ir & MSK_CALL) == OPC_CALL || (ir & MSK_JMP) == OPC_JMP) begin
      if (ir[5:3] == MODE_REGISTER) begin
        raise(ST_ILL_BIT, VEC_ILLEGAL);
        return;
      end
      d = (ir[5:3] == MODE_REG_DEF) ? r[ir[2:0]] : dstv;
      if (ir[5:0] == DST_AUTOINC_DEF_SP) begin
        d = em[sp[8:1]];
        sp += 2;
      end
      if ((ir & MSK_CALL) == OPC_CALL) begin
        sp -= 2;
        em[sp[8:1]] = r[lr];
        r[lr] = r[7];
      end
      r[6] = sp;
      r[7] = d;
    end else if ((ir & MSK_RTS) == OPC_RTS) begin
      r[7] = r[ir[2:0]];
      r[ir[2:0]] = em[sp[8:1]];
      r[6] = sp + 2;
    end else if ((ir & MSK_MARK) == OPC_MARK) begin
      sp = (r[7] + 2 * ir[5:0]) & 32'h0000_FFFF;
      r[7] = r[5];
      r[5] = em[sp[8:1]];
      r[6] = sp + 2;
    end else if ((ir & MSK_SPL) == OPC_SPL) begin
      if (psw[15:14] == PSW_MODE_KERNEL) psw[7:5] = ir[2:0];
      return;
    end else if ((ir & MSK_SOB) == OPC_SOB) begin
      r[lr] = (r[lr] - 1) & 32'h0000_FFFF;
      if (r[lr] != 0) r[7] = (r[7] - 2 * ir[5:0]) & 32'h0000_FFFF;
    end else begin
      raise(ST_RSV_BIT, VEC_RESERVED);
      return;
    end
    if (r[7][0]) raise(ST_BND_BIT, VEC_BUSERR);
  endtask

  // load state, launch, poll busy, then compare everything with the reference
  task automatic run(input logic [15:0] ir, input bit poke);
    logic [31:0] v;
    int          n;
    for (int i = 0; i < 8; i++) wr(OFF_GR0 + 8'(4 * i), r[i]);
    wr(OFF_PSW, psw);
    wr(OFF_DST, dstv);
    wr(OFF_STATUS, 32'h0000_001E);
    flg = 0;
    wr(OFF_INSTR, ir);
    if (poke) wr(OFF_GR0, 32'h0000_5A5A);
    n = 0;
    do begin
      rd(OFF_STATUS, v);
      n++;
    end while (v[ST_BUSY_BIT] !== 1'b0 && n < 40);
    if (n >= 40) give_up();
    if (poke) chk(v[ST_REF_BIT], 1'b1, "write while busy");
    model(ir);
    for (int i = 0; i < 8; i++) begin
      rd(OFF_GR0 + 8'(4 * i), v);
      chk(v, r[i], "register");
    end
    rd(OFF_PSW, v);
    chk(v, psw, "status word");
    rd(OFF_STATUS, v);
    chk(v & 32'h0000_FF0F, vec << 8 | flg, "trap flags");
    chk(trap_vec, vec, "trap vector");
    chk(traps_seen, n_traps, "trap pulses");
    for (int i = 0; i < 256; i++) chk(i_spc_mem_model.mem[i], em[i], "memory");
  endtask

  initial begin
    rst_i = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    slow = 1'b0;
    vec = 0;
    void'($urandom(79998));
    for (int i = 0; i < 256; i++) begin
      em[i] = $urandom & 32'h0000_FFFF;
      i_spc_mem_model.mem[i] = 16'(em[i]);
    end
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    // reset values, then an unmapped word that must read zero
    for (int i = 0; i < 9; i++) begin
      rd(OFF_GR0 + 8'(4 * i), v0);
      chk(v0, 32'h0000_0000, "reset value");
    end
    wr(8'h40, 32'h0000_FFFF);
    rd(8'h40, v0);
    chk(v0, 32'h0000_0000, "unmapped");
    for (int k = 0; k < 48; k++) begin
      rr = $urandom_range(0, 5);
      rs = $urandom_range(0, 5);
      for (int i = 0; i < 6; i++) r[i] = $urandom & 32'h0000_FFFE;
      r[6] = 32'h0000_0100 + 2 * $urandom_range(0, 63);
      r[7] = 32'h0000_0040 + 2 * $urandom_range(0, 31);
      psw = $urandom & 32'h0000_C0EF;
      dstv = $urandom & 32'h0000_01FE;
      slow <= (k % 12 == 0);
      case (k % 12)
        0: run(OPC_CALL | 16'(rr << 6 | 8 | rs), k == 0);
        1: run(OPC_CALL | 16'(rr << 6 | 48 | rs), 1'b0);
        2: run(OPC_CALL | 16'(rr << 6 | rs), 1'b0);
        3: run(OPC_CALL | 16'h01C0 | DST_AUTOINC_DEF_SP, 1'b0);
        4: run(OPC_RTS | 16'(k < 12 ? 7 : rr), 1'b0);
        5: run(OPC_MARK | 16'(k < 12 ? 63 : rs), 1'b0);
        6: begin
          psw[14] = k > 12;
          psw[15] = k > 30;
          run(OPC_SPL | 16'(rs), 1'b0);
        end
        7: run(OPC_JMP | (k == 19 ? 16'(DST_AUTOINC_DEF_SP) : 16'(8 | rs)), 1'b0);
        8: run(OPC_JMP | 16'(rs), 1'b0);
        9: begin
          r[rs] |= 1;
          run(OPC_JMP | 16'(8 | rs), 1'b0);
        end
        10: begin
          if (k < 24) r[rr] = 1;
          run(OPC_SOB | 16'(rr << 6 | (k < 12 ? 63 : rs)), 1'b0);
        end
        default: run(k < 12 ? 16'h0007 : 16'hFFFF, 1'b0);
      endcase
    end
    final_report();
  end
endmodule

// *** rtl/spc_exec.sv ***
/*
  Execution engine for call-with-linkage, return, stack-cleanup return,
  set-priority, unconditional transfer and decrement-and-loop-branch,
  with the illegal, reserved and boundary trap conditions flagged in status.
  Assumes an AHB-Lite master for software access, a word memory answering
  mem_req_o with a one-cycle mem_ack_i, and destination addressing other than
  register, register-deferred and @(SP)+ being evaluated outside into the DST register.
*/
// Notes on behaviour
// RULE1: call computes destination into a temporary before touching stack or registers.
// RULE2: call pushes linkage register (SP minus 2), loads it with PC, PC gets destination.
// RULE3: call and jump load PC with the destination address itself.
// RULE4: call with PC linkage and @(SP)+ swaps top of stack with PC.
// RULE5: return copies register to PC, pops stack into register, SP plus 2.
// RULE6: cleanup return: SP = PC + 2*count, PC = register five, pop register five.
// RULE7: set-priority copies instruction low three bits into status bits 7-5.
// RULE8: set-priority does nothing outside kernel mode.
// RULE9: set-priority, jump, cleanup return and loop branch keep condition codes.
// RULE10: jump with register-mode destination raises illegal instruction, no transfer.
// RULE11: jump register-deferred transfers to address held in the register.
// RULE12: fetching from an odd PC raises a boundary error.
// RULE13: loop branch decrements register; if nonzero PC minus twice offset.
// RULE14: loop offset is unsigned six bits, so branches only go backward.
// RULE15: software maps the stack into instruction and data space before cleanup return.
// RULE16: reserved opcodes trap through vector 10, illegal ones through 4.
// RULE17: boundary errors trap as bus errors through vector 4.
// RULE18: stack accesses are words; push predecrements by two, pop postincrements.
module spc_exec
  import spc_pkg::*;
(
  input  wire logic        clock_i,      // 50 MHz clock
  input  wire logic        rst_i,        // synchronous reset, high
  input  wire logic        hsel_i,       // ahb slave select
  input  wire logic [31:0] haddr_i,      // ahb address
  input  wire logic [1:0]  htrans_i,     // ahb transfer type
  input  wire logic        hwrite_i,     // ahb write
  input  wire logic [2:0]  hsize_i,      // ahb size
  input  wire logic [31:0] hwdata_i,     // ahb write data
  input  wire logic        hready_i,     // ahb bus ready
  output logic             hreadyout_o,  // ahb slave ready
  output logic [31:0]      hrdata_o,     // ahb read data
  output logic             hresp_o,      // ahb response, always okay
  output logic             mem_req_o,    // memory request level
  output logic             mem_we_o,     // memory write
  output logic [15:0]      mem_addr_o,   // memory byte address
  output logic [15:0]      mem_wdata_o,  // memory write word
  input  wire logic [15:0] mem_rdata_i,  // memory read word
  input  wire logic        mem_ack_i,    // memory done, one cycle
  output logic             trap_o,       // pulse: a trap condition was raised
  output logic [7:0]       trap_vec_o    // vector of the last trap
);

  typedef struct packed {
    spc_state_t       st;
    logic [7:0][15:0] gr;
    logic [15:0]      psw;
    logic [15:0]      ir;
    logic [15:0]      tmp;
    logic [15:0]      dst;
    logic             ill;
    logic             rsv;
    logic             bnd;
    logic             refused;
    logic [7:0]       vec;
    logic             trap;
    logic             wr_act;
    logic [7:0]       wr_addr;
    logic [31:0]      hrdata;
    logic             mem_req;
    logic             mem_we;
    logic [15:0]      mem_addr;
    logic [15:0]      mem_wdata;
  } spc_regs_t;

  spc_regs_t r;
  spc_regs_t next_r;

  // destination for call and jump: register-deferred uses the register itself
  function automatic logic [15:0] dest_addr(input logic [15:0] ir, input logic [7:0][15:0] gr,
                                            input logic [15:0] dst);
    if (ir[5:3] == MODE_REG_DEF) begin
      dest_addr = gr[ir[2:0]];
    end else begin
      dest_addr = dst;
    end
  endfunction

  function automatic logic op_is(input logic [15:0] ir, input logic [15:0] msk, input logic [15:0] opc);
    op_is = ((ir & msk) == opc);
  endfunction

  logic        ahb_go;
  logic        start;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [2:0]  rsel;
  logic [15:0] sob_val;

  assign ahb_go  = hsel_i && htrans_i[1] && hready_i;
  assign start   = r.wr_act && (r.wr_addr == OFF_INSTR) && (r.st == ST_IDLE);
  assign sp      = r.gr[IDX_SP];
  assign pc      = r.gr[IDX_PC];
  assign rsel    = r.ir[8:6];
  assign sob_val = r.gr[hwdata_i[8:6]] - 16'h0001;

  // next-state: bus slave, then the execution sequencer
  always_comb begin
    logic [15:0] nir;
    logic        push_go;
    logic        trap_ill;
    logic        trap_rsv;
    logic        trap_bnd;
    logic [15:0] sp_now;
    nir      = hwdata_i[15:0];
    sp_now   = sp;
    push_go  = 1'b0;
    trap_ill = 1'b0;
    trap_rsv = 1'b0;
    trap_bnd = 1'b0;
    next_r   = r;
    next_r.trap   = 1'b0;
    next_r.wr_act = ahb_go && hwrite_i;
    next_r.wr_addr = haddr_i[7:0];

    // read data registered in the address phase so hrdata comes from a flop
    if (ahb_go && !hwrite_i) begin
      if (haddr_i[7:0] < OFF_PSW && haddr_i[1:0] == 2'h0) begin
        next_r.hrdata = {16'h0000, r.gr[haddr_i[4:2]]};
      end else if (haddr_i[7:0] == OFF_PSW) begin
        next_r.hrdata = {16'h0000, r.psw};
      end else if (haddr_i[7:0] == OFF_INSTR) begin
        next_r.hrdata = {16'h0000, r.ir};
      end else if (haddr_i[7:0] == OFF_DST) begin
        next_r.hrdata = {16'h0000, r.dst};
      end else if (haddr_i[7:0] == OFF_STATUS) begin
        next_r.hrdata = {16'h0000, r.vec, 3'h0, r.refused, r.bnd, r.rsv, r.ill, (r.st != ST_IDLE)};
      end else begin
        next_r.hrdata = 32'h0000_0000;  // unmapped reads as zero
      end
    end

    // write data phase; state writes are refused while an instruction runs
    if (r.wr_act) begin
      if (r.wr_addr == OFF_STATUS) begin
        if (hwdata_i[ST_ILL_BIT]) next_r.ill = 1'b0;
        if (hwdata_i[ST_RSV_BIT]) next_r.rsv = 1'b0;
        if (hwdata_i[ST_BND_BIT]) next_r.bnd = 1'b0;
        if (hwdata_i[ST_REF_BIT]) next_r.refused = 1'b0;
      end else if (r.st != ST_IDLE) begin
        if (r.wr_addr <= OFF_DST) next_r.refused = 1'b1;
      end else if (r.wr_addr < OFF_PSW && r.wr_addr[1:0] == 2'h0) begin
        next_r.gr[r.wr_addr[4:2]] = hwdata_i[15:0];
      end else if (r.wr_addr == OFF_PSW) begin
        next_r.psw = hwdata_i[15:0];
      end else if (r.wr_addr == OFF_DST) begin
        next_r.dst = hwdata_i[15:0];
      end else if (r.wr_addr == OFF_INSTR) begin
        next_r.ir = nir;
      end
    end

    // sequencer
    case (r.st)
      ST_IDLE: begin
        if (start) begin
          if (op_is(nir, MSK_CALL, OPC_CALL)) begin
            if (nir[5:3] == MODE_REGISTER) begin
              trap_ill = 1'b1;                                      // RULE16
            end else if (nir[5:0] == DST_AUTOINC_DEF_SP) begin
              if (sp[0]) begin
                trap_bnd = 1'b1;
              end else begin
                next_r.mem_req  = 1'b1;                             // RULE4
                next_r.mem_we   = 1'b0;
                next_r.mem_addr = sp;
                next_r.st       = ST_READ_TMP;
              end
            end else begin
              next_r.tmp = dest_addr(nir, r.gr, r.dst);             // RULE1
              push_go    = 1'b1;
            end
          end else if (op_is(nir, MSK_RTS, OPC_RTS)) begin
            next_r.gr[IDX_PC] = r.gr[nir[2:0]];                     // RULE5
            if (sp[0]) begin
              trap_bnd = 1'b1;
            end else begin
              next_r.mem_req  = 1'b1;
              next_r.mem_we   = 1'b0;
              next_r.mem_addr = sp;
              next_r.st       = ST_POP;
            end
          end else if (op_is(nir, MSK_MARK, OPC_MARK)) begin
            next_r.gr[IDX_SP] = pc + {9'h000, nir[5:0], 1'b0};      // RULE6
            next_r.gr[IDX_PC] = r.gr[IDX_GR5];
            if (next_r.gr[IDX_SP][0]) begin
              trap_bnd = 1'b1;
            end else begin
              next_r.mem_req  = 1'b1;
              next_r.mem_we   = 1'b0;
              next_r.mem_addr = next_r.gr[IDX_SP];
              next_r.st       = ST_POP;
            end
          end else if (op_is(nir, MSK_SPL, OPC_SPL)) begin
            // only the priority field moves, codes stay
            if (r.psw[PSW_MODE_LSB +: 2] == PSW_MODE_KERNEL) begin   // RULE8
              next_r.psw[PSW_PRI_LSB +: 3] = nir[2:0];              // RULE7 RULE9
            end
          end else if (op_is(nir, MSK_JMP, OPC_JMP)) begin
            if (nir[5:3] == MODE_REGISTER) begin
              trap_ill = 1'b1;                                      // RULE10
            end else if (nir[5:0] == DST_AUTOINC_DEF_SP) begin
              if (sp[0]) begin
                trap_bnd = 1'b1;
              end else begin
                next_r.mem_req  = 1'b1;
                next_r.mem_we   = 1'b0;
                next_r.mem_addr = sp;
                next_r.st       = ST_READ_TMP;
              end
            end else begin
              next_r.gr[IDX_PC] = dest_addr(nir, r.gr, r.dst);      // RULE3 RULE11
              next_r.st         = ST_CHECK;
            end
          end else if (op_is(nir, MSK_SOB, OPC_SOB)) begin
            next_r.gr[nir[8:6]] = sob_val;                          // RULE13
            if (sob_val != 16'h0000) begin
              // zero-extended offset: the step is always backward
              next_r.gr[IDX_PC] = pc - {9'h000, nir[5:0], 1'b0};    // RULE14
            end
            next_r.st = ST_CHECK;
          end else begin
            trap_rsv = 1'b1;                                        // RULE16
          end
        end
      end
      ST_READ_TMP: begin
        if (mem_ack_i) begin
          next_r.mem_req    = 1'b0;
          next_r.gr[IDX_SP] = sp + WORD_BYTES;                      // RULE18
          if (op_is(r.ir, MSK_CALL, OPC_CALL)) begin
            next_r.tmp = mem_rdata_i;                               // RULE1
            push_go    = 1'b1;
          end else begin
            next_r.gr[IDX_PC] = mem_rdata_i;
            next_r.st         = ST_CHECK;
          end
        end
      end
      ST_PUSH: begin
        if (mem_ack_i) begin
          next_r.mem_req    = 1'b0;
          next_r.gr[rsel]   = pc;                                   // RULE2
          next_r.gr[IDX_PC] = r.tmp;                                // RULE3
          next_r.st         = ST_CHECK;
        end
      end
      ST_POP: begin
        if (mem_ack_i) begin
          next_r.mem_req    = 1'b0;
          next_r.gr[IDX_SP] = sp + WORD_BYTES;                      // RULE18
          if (op_is(r.ir, MSK_MARK, OPC_MARK)) begin
            next_r.gr[IDX_GR5] = mem_rdata_i;                       // RULE6
          end else begin
            next_r.gr[r.ir[2:0]] = mem_rdata_i;                     // RULE5
          end
          next_r.st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // the next fetch comes from the new PC; odd means a boundary error
        trap_bnd  = pc[0];                                          // RULE12
        next_r.st = ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    // shared push: predecrement from the live SP, since a swap call has just popped
    if (push_go) begin
      sp_now = next_r.gr[IDX_SP];
      if (sp_now[0]) begin
        trap_bnd  = 1'b1;
        next_r.st = ST_IDLE;
      end else begin
        next_r.gr[IDX_SP] = sp_now - WORD_BYTES;                    // RULE2 RULE18
        next_r.mem_req    = 1'b1;
        next_r.mem_we     = 1'b1;
        next_r.mem_addr   = sp_now - WORD_BYTES;
        next_r.mem_wdata  = (r.st == ST_IDLE) ? r.gr[nir[8:6]] : r.gr[rsel];
        next_r.st         = ST_PUSH;
      end
    end

    // trap flags: hardware set wins over a software clear in the same cycle
    if (trap_ill) begin
      next_r.ill = 1'b1;
      next_r.vec = VEC_ILLEGAL;
    end
    if (trap_rsv) begin
      next_r.rsv = 1'b1;
      next_r.vec = VEC_RESERVED;
    end
    if (trap_bnd) begin
      next_r.bnd = 1'b1;
      next_r.vec = VEC_BUSERR;                                      // RULE17
    end
    next_r.trap = trap_ill || trap_rsv || trap_bnd;
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r     <= '0;
      r.st  <= ST_IDLE;
      r.psw <= PSW_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout_o = 1'b1;   // zero-wait slave: every access is single cycle
  assign hresp_o     = 1'b0;
  assign hrdata_o    = r.hrdata;
  assign mem_req_o   = r.mem_req;
  assign mem_we_o    = r.mem_we;
  assign mem_addr_o  = r.mem_addr;
  assign mem_wdata_o = r.mem_wdata;
  assign trap_o      = r.trap;
  assign trap_vec_o  = r.vec;

  AST_SPL_KERNEL: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE7
    start && op_is(hwdata_i[15:0], MSK_SPL, OPC_SPL) && r.psw[15:14] == PSW_MODE_KERNEL
    |=> r.psw[7:5] == $past(hwdata_i[2:0]))
    else $error("priority not loaded");
  AST_SPL_NOOP: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE8
    start && op_is(hwdata_i[15:0], MSK_SPL, OPC_SPL) && r.psw[15:14] != PSW_MODE_KERNEL
    |=> $stable(r.psw))
    else $error("priority changed outside kernel");
  AST_CC_KEPT: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE9
    r.st != ST_IDLE |=> $stable(r.psw[3:0]))
    else $error("condition codes changed during execution");
  AST_JMP_REG: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE10
    start && op_is(hwdata_i[15:0], MSK_JMP, OPC_JMP) && hwdata_i[5:3] == MODE_REGISTER
    |=> r.ill && r.vec == VEC_ILLEGAL && $stable(r.gr[IDX_PC]) ##1 r.st == ST_IDLE)
    else $error("register-mode jump not refused");
  AST_PUSH_SP: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE2
    r.st != ST_PUSH && next_r.st == ST_PUSH
    |=> r.mem_we && r.mem_addr == r.gr[IDX_SP]
        && r.gr[IDX_SP] == $past(sp) - (($past(r.st) == ST_READ_TMP) ? 16'h0000 : 16'h0002))
    else $error("push did not predecrement");
  AST_POP_SP: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE18
    r.st == ST_POP && mem_ack_i |=> r.gr[IDX_SP] == $past(r.gr[IDX_SP]) + 16'h0002 ##1 r.st == ST_IDLE)
    else $error("pop did not postincrement");
  AST_SOB_BACK: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE13
    start && op_is(hwdata_i[15:0], MSK_SOB, OPC_SOB) && sob_val != 16'h0000
    |=> r.gr[IDX_PC] == $past(pc) - {9'h000, $past(hwdata_i[5:0]), 1'b0})
    else $error("loop branch target wrong");
  AST_ODD_FETCH: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE12
    r.st == ST_CHECK && pc[0] |=> r.bnd && r.trap && r.vec == VEC_BUSERR)
    else $error("odd fetch not flagged");
  AST_RSV: assert property (@(posedge clock_i) disable iff (rst_i)  // RULE16
    r.trap && r.rsv && !$past(r.rsv) |-> r.vec == VEC_RESERVED || r.bnd || r.ill)
    else $error("reserved vector wrong");

endmodule

// *** rtl/spc_pkg.sv ***
/*
  Shared constants for the subroutine and program-control execution block:
  register offsets, status fields, opcode match patterns, trap vectors, states.
  Assumes a 32-bit AHB-Lite register bus and a 16-bit word memory port.
*/
package spc_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFF_GR0    = 8'h00;  // general registers 0..7 at 0x00..0x1C
  localparam logic [7:0] OFF_PSW    = 8'h20;
  localparam logic [7:0] OFF_INSTR  = 8'h24;  // write launches execution
  localparam logic [7:0] OFF_DST    = 8'h28;  // precomputed destination address
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  // status bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ILL_BIT  = 1;
  localparam int ST_RSV_BIT  = 2;
  localparam int ST_BND_BIT  = 3;
  localparam int ST_REF_BIT  = 4;
  localparam int ST_VEC_LSB  = 8;
  // status word fields
  localparam int PSW_PRI_LSB  = 5;
  localparam int PSW_MODE_LSB = 14;
  localparam logic [1:0]  PSW_MODE_KERNEL = 2'h0;
  localparam logic [15:0] PSW_RESET       = 16'h0000;
  // register indices
  localparam logic [2:0] IDX_GR5 = 3'h5;
  localparam logic [2:0] IDX_SP  = 3'h6;
  localparam logic [2:0] IDX_PC  = 3'h7;
  // opcode patterns: (ir & mask) == match
  localparam logic [15:0] MSK_CALL = 16'hFE00;
  localparam logic [15:0] OPC_CALL = 16'h0800;
  localparam logic [15:0] MSK_RTS  = 16'hFFF8;
  localparam logic [15:0] OPC_RTS  = 16'h0080;  // 00020r
  localparam logic [15:0] MSK_SPL  = 16'hFFF8;
  localparam logic [15:0] OPC_SPL  = 16'h0098;
  localparam logic [15:0] MSK_MARK = 16'hFFC0;
  localparam logic [15:0] OPC_MARK = 16'h0D00;
  localparam logic [15:0] MSK_JMP  = 16'hFFC0;
  localparam logic [15:0] OPC_JMP  = 16'h0040;
  localparam logic [15:0] MSK_SOB  = 16'hFE00;
  localparam logic [15:0] OPC_SOB  = 16'h7E00;
  localparam logic [5:0]  DST_AUTOINC_DEF_SP = 6'h1E;  // @(SP)+
  localparam logic [2:0]  MODE_REGISTER = 3'h0;
  localparam logic [2:0]  MODE_REG_DEF  = 3'h1;
  // trap vectors (octal 4 and octal 10)
  localparam logic [7:0] VEC_ILLEGAL  = 8'h04;
  localparam logic [7:0] VEC_RESERVED = 8'h08;
  localparam logic [7:0] VEC_BUSERR   = 8'h04;
  localparam logic [15:0] WORD_BYTES  = 16'h0002;

  typedef enum logic [2:0] {ST_IDLE, ST_READ_TMP, ST_PUSH, ST_POP, ST_CHECK} spc_state_t;
endpackage
